// *** pcmr_pkg.sv ***
// Purpose: shared constants and carriers for the converter/regulator mode registers
// Assumes: 8-bit special-function register space, byte-wide accesses
// Notes: offsets are the special-function register addresses
package pcmr_pkg;
   // register addresses
   localparam logic [7:0] CONVERTER_MODE_ADDR = 8'h94;
   localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'hc9;
   // converter_mode field positions
   localparam int BYPASS_ACTIVE_FLAG_BIT = 3;
   localparam int BYPASS_SELECT_HI = 2;
   localparam int BYPASS_SELECT_LO = 1;
   localparam int PASSIVE_DIODE_ENABLE_BIT = 0;
   // regulator_control field positions
   localparam int OSC_BIAS_BIT = 4;
   // reset values
   localparam logic [1:0] BYPASS_SELECT_RST = 2'h0;
   localparam logic PASSIVE_DIODE_RST = 1'b0;
   localparam logic OSC_BIAS_RST = 1'b1;
   // bias settling time, for software reference
   localparam int OSC_BIAS_SETTLE_US = 4;
   localparam int CORE_CLK_MHZ = 25;
   localparam int OSC_BIAS_SETTLE_CYC = OSC_BIAS_SETTLE_US * CORE_CLK_MHZ;

   // bypass select encodings
   typedef enum logic [1:0] {
      BYP_OFF = 2'h0,
      BYP_AUTO_FAST = 2'h1,
      BYP_AUTO_LOWPWR = 2'h2,
      BYP_FORCED = 2'h3
   } pcmr_bypass_e;

   // power mode request from the power manager
   typedef struct packed {
      logic sleep;
      logic suspend;
   } pcmr_pwr_s;

   // controls toward the analog converter and regulator
   typedef struct packed {
      logic bypass_auto_en;
      logic bypass_force;
      logic dcdc_osc_en;
      logic passive_diode_en;
      logic core_regulator_en;
      logic osc_bias_en;
   } pcmr_ctl_s;
endpackage : pcmr_pkg

// *** pcmr_regs.sv ***
// Purpose: special-function register logic for converter and regulator modes
// Assumes: cpu presents one-cycle write and read strobes on core_clk
// Notes: analog circuits sit outside; only their control levels are made here
//
// Contract
// RULE1: converter mode bits 7:4 read zero and ignore writes.
// RULE2: converter mode bit 3 reads one while the converter is in bypass.
// RULE3: bypass select 00 keeps bypass disabled.
// RULE4: bypass select 01 allows auto bypass with the converter oscillator running.
// RULE5: bypass select 10 allows auto bypass with the converter oscillator stopped.
// RULE6: bypass select 11 forces the converter into bypass.
// RULE7: converter mode bit 0 enables passive diode mode when one.
// RULE8: the core regulator turns off in sleep and stays on in suspend.
// RULE9: regulator control bit 4 forces the oscillator bias on, off when zero outside sleep.
// RULE10: software waits 4 us after re-enabling the bias before using the oscillator.
// RULE11: software clears the bias only while the precision oscillator is idle.
// RULE12: regulator control bits 3:1 and 7 read zero and ignore writes.
// RULE13: regulator control reserved bits 6, 5 and 0 read zero and take writes of zero.
// RULE14: reset clears bypass select and passive diode enable and sets the bias enable.
module pcmr_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // cpu register access
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // converter status and power mode
   input wire logic bypass_status_pin,
   input wire pcmr_pkg::pcmr_pwr_s pwr_mode,
   // analog controls
   output pcmr_pkg::pcmr_ctl_s ctl
);
   import pcmr_pkg::*;

   logic [1:0] byp_sel_q, byp_sel_d;
   logic passive_diode_enable_q, passive_diode_enable_d;
   logic bias_q, bias_d;
   logic byp_meta_q, byp_sync_q;
   logic sleep_meta_q, sleep_sync_q, susp_meta_q, susp_sync_q;
   logic [7:0] rdata_d;
   pcmr_ctl_s ctl_d;

   // address match, shared by the write and read decoders
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] place);
      return a == place;
   endfunction

   // bypass status is analog, so it is synchronised before any read
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         byp_meta_q <= 1'b0;
         byp_sync_q <= 1'b0;
         sleep_meta_q <= 1'b0;
         sleep_sync_q <= 1'b0;
         susp_meta_q <= 1'b0;
         susp_sync_q <= 1'b0;
      end else begin
         byp_meta_q <= bypass_status_pin;
         byp_sync_q <= byp_meta_q;
         sleep_meta_q <= pwr_mode.sleep;
         sleep_sync_q <= sleep_meta_q;
         susp_meta_q <= pwr_mode.suspend;
         susp_sync_q <= susp_meta_q;
      end
   end

   // writable fields next values
   always_comb begin
      byp_sel_d = byp_sel_q;
      passive_diode_enable_d = passive_diode_enable_q;
      bias_d = bias_q;
      if (reg_wr && addr_hit(reg_addr, CONVERTER_MODE_ADDR)) begin
         // RULE1: upper bits dropped
         byp_sel_d = reg_wdata[BYPASS_SELECT_HI:BYPASS_SELECT_LO];
         // RULE7: passive diode bit
         passive_diode_enable_d = reg_wdata[PASSIVE_DIODE_ENABLE_BIT];
      end
      if (reg_wr && addr_hit(reg_addr, REGULATOR_CONTROL_ADDR)) begin
         // RULE12: only the bias bit is stored
         bias_d = reg_wdata[OSC_BIAS_BIT];
      end
   end

   // RULE14: reset values
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         byp_sel_q <= BYPASS_SELECT_RST;
         passive_diode_enable_q <= PASSIVE_DIODE_RST;
         bias_q <= OSC_BIAS_RST;
      end else begin
         byp_sel_q <= byp_sel_d;
         passive_diode_enable_q <= passive_diode_enable_d;
         bias_q <= bias_d;
      end
   end

   // read mux and analog controls
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd && addr_hit(reg_addr, CONVERTER_MODE_ADDR)) begin
         // RULE2: live bypass flag
         rdata_d[BYPASS_ACTIVE_FLAG_BIT] = byp_sync_q;
         rdata_d[BYPASS_SELECT_HI:BYPASS_SELECT_LO] = byp_sel_q;
         rdata_d[PASSIVE_DIODE_ENABLE_BIT] = passive_diode_enable_q;
      end
      if (reg_rd && addr_hit(reg_addr, REGULATOR_CONTROL_ADDR)) begin
         // RULE13: reserved bits stay zero
         rdata_d[OSC_BIAS_BIT] = bias_q;
      end
      ctl_d = '0;
      case (pcmr_bypass_e'(byp_sel_q))
         // RULE3: bypass disabled
         BYP_OFF: begin
            ctl_d.dcdc_osc_en = 1'b1;
         end
         // RULE4: auto, oscillator on
         BYP_AUTO_FAST: begin
            ctl_d.bypass_auto_en = 1'b1;
            ctl_d.dcdc_osc_en = 1'b1;
         end
         // RULE5: auto, oscillator off
         BYP_AUTO_LOWPWR: begin
            ctl_d.bypass_auto_en = 1'b1;
         end
         // RULE6: forced bypass
         BYP_FORCED: begin
            ctl_d.bypass_force = 1'b1;
         end
         default: begin
            ctl_d.dcdc_osc_en = 1'b1;
         end
      endcase
      ctl_d.passive_diode_en = passive_diode_enable_q;
      // RULE8: regulator off only in sleep
      ctl_d.core_regulator_en = !sleep_sync_q;
      // RULE9: bias follows bit outside sleep
      ctl_d.osc_bias_en = bias_q && !sleep_sync_q;
   end

   // outputs registered; read data valid the cycle after the strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         ctl <= '{bypass_auto_en: 1'b0, bypass_force: 1'b0, dcdc_osc_en: 1'b1,
                  passive_diode_en: PASSIVE_DIODE_RST, core_regulator_en: 1'b1,
                  osc_bias_en: OSC_BIAS_RST};
      end else begin
         reg_rdata <= rdata_d;
         ctl <= ctl_d;
      end
   end

   // RULE1: upper converter bits read zero
   property p_conv_upper_zero;
      @(posedge core_clk) disable iff (!resetn)
         (reg_rd && reg_addr == CONVERTER_MODE_ADDR) |=> reg_rdata[7:4] == 4'h0;
   endproperty
   a_conv_upper_zero: assert property (p_conv_upper_zero) else $error("converter upper bits"); // RULE1

   property p_flag_follows;
      @(posedge core_clk) disable iff (!resetn)
         (reg_rd && reg_addr == CONVERTER_MODE_ADDR) |=>
            reg_rdata[BYPASS_ACTIVE_FLAG_BIT] == $past(byp_sync_q);
   endproperty
   a_flag_follows: assert property (p_flag_follows) else $error("bypass flag wrong"); // RULE2

   property p_sel_off;
      @(posedge core_clk) disable iff (!resetn)
         byp_sel_q == 2'h0 |=> !ctl.bypass_auto_en && !ctl.bypass_force;
   endproperty
   a_sel_off: assert property (p_sel_off) else $error("bypass not disabled"); // RULE3

   property p_sel_fast;
      @(posedge core_clk) disable iff (!resetn)
         byp_sel_q == 2'h1 |=> ctl.bypass_auto_en && ctl.dcdc_osc_en;
   endproperty
   a_sel_fast: assert property (p_sel_fast) else $error("auto fast wrong"); // RULE4

   property p_sel_low;
      @(posedge core_clk) disable iff (!resetn)
         byp_sel_q == 2'h2 |=> ctl.bypass_auto_en && !ctl.dcdc_osc_en;
   endproperty
   a_sel_low: assert property (p_sel_low) else $error("auto low power wrong"); // RULE5

   property p_sel_force;
      @(posedge core_clk) disable iff (!resetn)
         byp_sel_q == 2'h3 |=> ctl.bypass_force;
   endproperty
   a_sel_force: assert property (p_sel_force) else $error("forced bypass wrong"); // RULE6

   property p_diode_write;
      @(posedge core_clk) disable iff (!resetn)
         (reg_wr && reg_addr == CONVERTER_MODE_ADDR) |=> ##1
            ctl.passive_diode_en == $past(reg_wdata[PASSIVE_DIODE_ENABLE_BIT], 2);
   endproperty
   a_diode_write: assert property (p_diode_write) else $error("diode enable wrong"); // RULE7

   property p_sleep_reg;
      @(posedge core_clk) disable iff (!resetn)
         sleep_sync_q |=> !ctl.core_regulator_en && !ctl.osc_bias_en;
   endproperty
   a_sleep_reg: assert property (p_sleep_reg) else $error("regulator on in sleep"); // RULE8

   // RULE8: suspend keeps the regulator
   property p_susp_reg;
      @(posedge core_clk) disable iff (!resetn)
         (susp_sync_q && !sleep_sync_q) |=> ctl.core_regulator_en;
   endproperty
   a_susp_reg: assert property (p_susp_reg) else $error("regulator off in suspend"); // RULE8

   property p_bias_write;
      @(posedge core_clk) disable iff (!resetn)
         (reg_wr && reg_addr == REGULATOR_CONTROL_ADDR && !sleep_sync_q) ##1 !sleep_sync_q
            |=> ctl.osc_bias_en == $past(reg_wdata[OSC_BIAS_BIT], 2);
   endproperty
   a_bias_write: assert property (p_bias_write) else $error("bias enable wrong"); // RULE9

   property p_regctl_zero;
      @(posedge core_clk) disable iff (!resetn)
         (reg_rd && reg_addr == REGULATOR_CONTROL_ADDR) |=> reg_rdata[7:5] == 3'h0
            && reg_rdata[3:0] == 4'h0;
   endproperty
   a_regctl_zero: assert property (p_regctl_zero) else $error("regulator unused bits"); // RULE12
endmodule : pcmr_regs

// *** pcmr_regs_tb.sv ***
// Purpose: self-checking bench for the converter and regulator mode registers
// Assumes: one-cycle read and write strobes, read data one cycle after the strobe
// Notes: the bench drives the ports itself; the design carries its own assertions
module pcmr_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pcmr_pkg::*;

   logic core_clk, resetn, reg_wr, reg_rd, bypass_status_pin;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   pcmr_pwr_s pwr_mode;
   pcmr_ctl_s ctl;
   int num_errors = 0;
   int samples_checked = 0;

   pcmr_regs pcmr_regs_inst (
      .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bypass_status_pin(bypass_status_pin), .pwr_mode(pwr_mode), .ctl(ctl)
   );

   // 25 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // compare one value, count it, report a mismatch at once
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle write strobe, launched just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // read data is registered, so it is taken just after the strobe edge
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(what, reg_rdata, exp);
      // back on an edge, so the next stimulus is launched there
      @(posedge core_clk);
   endtask

   // controls settle two edges after a write; masked bits are left unchecked
   task automatic chk_ctl(input logic [5:0] exp, input logic [5:0] m);
      repeat (2) @(posedge core_clk);
      #1 chk("ctl", {2'h0, 6'(ctl) & m}, {2'h0, exp & m});
      @(posedge core_clk);
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      resetn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      bypass_status_pin = 1'b0;
      pwr_mode = '0;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      chk_ctl(6'h0b, 6'h3f);
      chk_rd(CONVERTER_MODE_ADDR, 8'h00, "conv reset");
      chk_rd(REGULATOR_CONTROL_ADDR, 8'h10, "reg reset");
      // every select code, unused and flag bits written as ones
      for (int s = 0; s < 4; s++) begin
         wr(CONVERTER_MODE_ADDR, {5'h1f, 2'(s), s[0]});
         chk_rd(CONVERTER_MODE_ADDR, {5'h00, 2'(s), s[0]}, "conv mode");
         // oscillator state under forced bypass is left open
         chk_ctl({s == 1 || s == 2, s == 3, s != 2, s[0], 2'b11},
                 (s == 3) ? 6'h37 : 6'h3f);
      end
      // flag follows the converter status through its synchroniser
      bypass_status_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk_rd(CONVERTER_MODE_ADDR, 8'h0f, "flag set");
      bypass_status_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk_rd(CONVERTER_MODE_ADDR, 8'h07, "flag clear");
      // regulator control: only the bias bit is writable
      // reserved bits written as zero, unused bits as ones
      wr(REGULATOR_CONTROL_ADDR, 8'h9e);
      chk_rd(REGULATOR_CONTROL_ADDR, 8'h10, "reg ones");
      // precision oscillator idle in the bench before clearing
      wr(REGULATOR_CONTROL_ADDR, 8'h00);
      chk_rd(REGULATOR_CONTROL_ADDR, 8'h00, "reg zero");
      chk_ctl(6'h00, 6'h01);
      wr(REGULATOR_CONTROL_ADDR, 8'h10);
      // bias settles before the oscillator is relied on
      repeat (OSC_BIAS_SETTLE_CYC) @(posedge core_clk);
      chk_ctl(6'h01, 6'h01);
      // sleep drops regulator and bias, suspend keeps both
      pwr_mode <= 2'b10;
      @(posedge core_clk);
      chk_ctl(6'h00, 6'h03);
      pwr_mode <= 2'b01;
      @(posedge core_clk);
      chk_ctl(6'h03, 6'h03);
      pwr_mode <= 2'b00;
      // unmapped place reads zero and leaves converter mode alone
      wr(8'h95, 8'h00);
      chk_rd(8'h95, 8'h00, "unmapped");
      chk_rd(CONVERTER_MODE_ADDR, 8'h07, "conv kept");
      // reset in mid-run restores the bias after it was cleared
      // oscillator still idle when the bias is cleared
      wr(REGULATOR_CONTROL_ADDR, 8'h00);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      chk_ctl(6'h0b, 6'h3f);
      chk_rd(CONVERTER_MODE_ADDR, 8'h00, "conv rerst");
      chk_rd(REGULATOR_CONTROL_ADDR, 8'h10, "reg rerst");
      give_verdict();
   end

   // watchdog, well beyond the few hundred cycles the sequence needs
   initial begin
      #(40 * 2000);
      num_errors++;
      give_verdict();
   end
endmodule // pcmr_regs_tb
